// ===== logic/pwm_defs.svh
// Register offsets, field positions, reset values and counts of the PWM block
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PWM_OFS_PERIOD      8'h00
`define PWM_OFS_DUTY_LOW    8'h04
`define PWM_OFS_CTRL        8'h08
`define PWM_OFS_DUTY_BUF    8'h0c
`define PWM_OFS_TIMER_CTRL  8'h10
`define PWM_OFS_TIMER       8'h14
`define PWM_OFS_STATUS      8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PWM_CTRL_EN_BIT     0
`define PWM_CTRL_LSB_LO     4
`define PWM_CTRL_LSB_HI     5
`define PWM_TCTRL_PRE_LO    0
`define PWM_TCTRL_PRE_HI    1
`define PWM_TCTRL_ON_BIT    2
`define PWM_TCTRL_POST_LO   3
`define PWM_TCTRL_POST_HI   6
`define PWM_DBUF_LATCH_LO   8
`define PWM_DBUF_LATCH_HI   9

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PWM_RST_PERIOD      8'hff
`define PWM_RST_BYTE        8'h00

// ----------------------------------------------------------------------------
// Prescaler terminal counts (4 sub-steps times ratio 1, 4, 16, 64, minus one)
// ----------------------------------------------------------------------------
`define PWM_PRE_LAST_1      8'h03
`define PWM_PRE_LAST_4      8'h0f
`define PWM_PRE_LAST_16     8'h3f
`define PWM_PRE_LAST_64     8'hff

`endif

// ===== logic/pwm_pkg.sv
// Types of the PWM block
package pwm_pkg;

    // ------------------------------------------------------------------------
    // Prescale selection
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PRE_DIV1,
        PRE_DIV4,
        PRE_DIV16,
        PRE_DIV64
    } prescale_e;

    // ------------------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  pre;
        logic [7:0]  period_timer;
        logic [7:0]  period_register;
        logic [7:0]  duty_low_register;
        logic [1:0]  duty_lsb_field;
        logic [7:0]  duty_buffer_register;
        logic [1:0]  duty_latch;
        logic        pwm_en;
        logic        timer_on;
        prescale_e   prescale;
        logic [3:0]  postscale;
        logic        pin;
        logic [31:0] prdata;
    } pwm_state_s;

endpackage : pwm_pkg

// ===== logic/timer_based_pwm_output.sv
// Ten-bit PWM generator on an 8-bit period timer, with an APB register slave
// How it works
// - Timer equal to period on an increment: timer clears, new period begins.
// - Pin set at each period boundary, unless the duty value is zero.
// - At each boundary the written duty value is copied into the buffer.
// - The timer postscaler plays no part in the PWM period.
// - Duty is 10 bits: eight high in duty low, two low in control 5:4.
// - Duty may be written anytime; it only applies after the current period.
// - While PWM runs, writes to the duty buffer are ignored.
// - Buffer register plus 2-bit latch (read back at buffer bits 9:8) hold the active compare value.
// - Time base is timer (upper 8 bits) joined with two sub-count bits.
// - At prescale 1:1 the low bits are the clock sub-count.
// - Time base equal to buffered duty drives the pin low.
// - Duty beyond the period length leaves the pin unchanged.
// - Full 10-bit resolution only with period 255.
// - High time equals duty times clock period times prescale ratio.
`timescale 1ns/100ps
`include "pwm_defs.svh"

module timer_based_pwm_output (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             pwm_output_pin
);

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------
    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            `PWM_OFS_PERIOD, `PWM_OFS_DUTY_LOW, `PWM_OFS_CTRL, `PWM_OFS_DUTY_BUF,
            `PWM_OFS_TIMER_CTRL, `PWM_OFS_TIMER, `PWM_OFS_STATUS: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // Prescaler count that ends one timer increment
    function automatic logic [7:0] pre_last(input pwm_pkg::prescale_e p);
        case (p)
            pwm_pkg::PRE_DIV1:  pre_last = `PWM_PRE_LAST_1;
            pwm_pkg::PRE_DIV4:  pre_last = `PWM_PRE_LAST_4;
            pwm_pkg::PRE_DIV16: pre_last = `PWM_PRE_LAST_16;
            default:            pre_last = `PWM_PRE_LAST_64;
        endcase
    endfunction : pre_last

    // Two low time-base bits: the top two bits of the active prescaler span
    function automatic logic [1:0] low_bits(input pwm_pkg::prescale_e p,
                                            input logic [7:0] c);
        case (p)
            pwm_pkg::PRE_DIV1:  low_bits = c[1:0];
            pwm_pkg::PRE_DIV4:  low_bits = c[3:2];
            pwm_pkg::PRE_DIV16: low_bits = c[5:4];
            default:            low_bits = c[7:6];
        endcase
    endfunction : low_bits

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pwm_pkg::pwm_state_s st_reg;
    pwm_pkg::pwm_state_s st_next;

    logic        setup_ph;
    logic        access_ph;
    logic        wr_en;
    logic        tick;
    logic        boundary;
    logic [9:0]  duty_new;
    logic [9:0]  duty_act;
    logic [9:0]  tb_next;
    logic [9:0]  tb_last;

    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign wr_en     = access_ph && pwrite && addr_mapped(paddr);
    assign duty_new  = {st_reg.duty_low_register, st_reg.duty_lsb_field};
    assign duty_act  = {st_reg.duty_buffer_register, st_reg.duty_latch};
    // Postscale never enters here: period depends on prescale, timer, period only
    assign tick      = st_reg.timer_on && (st_reg.pre == pre_last(st_reg.prescale));
    assign boundary  = tick && (st_reg.period_timer == st_reg.period_register);
    assign tb_last   = {st_reg.period_register, 2'b11};

    // Zero-wait slave; read data was captured in the setup cycle
    assign pready         = 1'b1;
    assign pslverr        = access_ph && !addr_mapped(paddr);
    assign prdata         = st_reg.prdata;
    assign pwm_output_pin = st_reg.pin;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // Timer and prescaler
        if (st_reg.timer_on) begin
            if (tick) begin
                st_next.pre = 8'h00;
                if (boundary) begin
                    st_next.period_timer = 8'h00;
                end else begin
                    st_next.period_timer = st_reg.period_timer + 8'h01;
                end
            end else begin
                st_next.pre = st_reg.pre + 8'h01;
            end
        end

        // Double buffer: only the boundary, or a buffer write while PWM is off, moves a new duty into the compare
        if (boundary) begin
            st_next.duty_buffer_register = st_reg.duty_low_register;
            st_next.duty_latch           = st_reg.duty_lsb_field;
        end

        // Time base seen after this edge, upper timer bits and two sub bits
        tb_next = {st_next.period_timer, low_bits(st_reg.prescale, st_next.pre)};

        // Output pin; each time-base step lasts one clock times the ratio
        if (!st_reg.pwm_en) begin
            st_next.pin = 1'b0;
        end else if (boundary) begin
            st_next.pin = (duty_new != 10'h000);
        end else if (st_reg.timer_on && (tb_next == duty_act)) begin
            // Duty past the period never matches, so the pin just holds
            st_next.pin = 1'b0;
        end

        // Register writes, taken at the access edge
        if (wr_en) begin
            case (paddr)
                `PWM_OFS_PERIOD: begin
                    st_next.period_register = pwdata[7:0];
                end
                `PWM_OFS_DUTY_LOW: begin
                    st_next.duty_low_register = pwdata[7:0];
                end
                `PWM_OFS_CTRL: begin
                    st_next.pwm_en         = pwdata[`PWM_CTRL_EN_BIT];
                    st_next.duty_lsb_field = pwdata[`PWM_CTRL_LSB_HI:`PWM_CTRL_LSB_LO];
                end
                `PWM_OFS_DUTY_BUF: begin
                    // Boundary copy wins; while running the buffer is read-only
                    if (!st_reg.pwm_en && !boundary) begin
                        st_next.duty_buffer_register = pwdata[7:0];
                    end
                end
                `PWM_OFS_TIMER_CTRL: begin
                    st_next.prescale  = pwm_pkg::prescale_e'(
                        pwdata[`PWM_TCTRL_PRE_HI:`PWM_TCTRL_PRE_LO]);
                    st_next.timer_on  = pwdata[`PWM_TCTRL_ON_BIT];
                    st_next.postscale = pwdata[`PWM_TCTRL_POST_HI:`PWM_TCTRL_POST_LO];
                    st_next.pre       = 8'h00;
                end
                `PWM_OFS_TIMER: begin
                    // Software load restarts the sub-count as well
                    st_next.period_timer = pwdata[7:0];
                    st_next.pre          = 8'h00;
                end
                default: begin
                end
            endcase
        end

        // Read data, captured in the setup cycle
        if (setup_ph && !pwrite) begin
            case (paddr)
                `PWM_OFS_PERIOD:     st_next.prdata = {24'h000000, st_reg.period_register};
                `PWM_OFS_DUTY_LOW:   st_next.prdata = {24'h000000, st_reg.duty_low_register};
                `PWM_OFS_CTRL:       st_next.prdata = {26'h0, st_reg.duty_lsb_field,
                                                       3'h0, st_reg.pwm_en};
                `PWM_OFS_DUTY_BUF:   st_next.prdata = {22'h0, st_reg.duty_latch,
                                                       st_reg.duty_buffer_register};
                `PWM_OFS_TIMER_CTRL: st_next.prdata = {25'h0, st_reg.postscale,
                                                       st_reg.timer_on, st_reg.prescale};
                `PWM_OFS_TIMER:      st_next.prdata = {24'h000000, st_reg.period_timer};
                `PWM_OFS_STATUS:     st_next.prdata = {31'h0, st_reg.pin};
                default:             st_next.prdata = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.pre                  <= 8'h00;
            st_reg.period_timer         <= `PWM_RST_BYTE;
            st_reg.period_register      <= `PWM_RST_PERIOD;
            st_reg.duty_low_register    <= `PWM_RST_BYTE;
            st_reg.duty_lsb_field       <= 2'h0;
            st_reg.duty_buffer_register <= `PWM_RST_BYTE;
            st_reg.duty_latch           <= 2'h0;
            st_reg.pwm_en               <= 1'b0;
            st_reg.timer_on             <= 1'b0;
            st_reg.prescale             <= pwm_pkg::PRE_DIV1;
            st_reg.postscale            <= 4'h0;
            st_reg.pin                  <= 1'b0;
            st_reg.prdata               <= 32'h00000000;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    logic       tmr_wr;
    logic       buf_wr;
    logic       ctrl_wr;
    logic       low_wr;
    logic       pin_clr;
    logic [1:0] lsb_wd;
    logic [7:0] low_wd;
    logic [9:0] dbuf10;

    assign tmr_wr = wr_en && ((paddr == `PWM_OFS_TIMER) || (paddr == `PWM_OFS_TIMER_CTRL));
    assign buf_wr = wr_en && (paddr == `PWM_OFS_DUTY_BUF);
    assign dbuf10 = duty_act;
    assign ctrl_wr = wr_en && (paddr == `PWM_OFS_CTRL);
    assign low_wr  = wr_en && (paddr == `PWM_OFS_DUTY_LOW);
    assign lsb_wd  = pwdata[`PWM_CTRL_LSB_HI:`PWM_CTRL_LSB_LO];
    assign low_wd  = pwdata[7:0];
    // Every way the pin may fall: disabled, zero-duty boundary, or a compare hit
    assign pin_clr = !st_reg.pwm_en || boundary || (st_reg.timer_on && (tb_next == duty_act));

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        (boundary && !tmr_wr) |=> (st_reg.period_timer == 8'h00) && (st_reg.pre == 8'h00);
    endproperty
    a_wrap: assert property (p_wrap) else $error("timer did not clear at period end");

    property p_set;
        @(posedge pclk) disable iff (!presetn)
        (boundary && st_reg.pwm_en && (duty_new != 10'h000) && !wr_en) |=> pwm_output_pin;
    endproperty
    a_set: assert property (p_set) else $error("pin not set at period start");

    property p_zero;
        @(posedge pclk) disable iff (!presetn)
        (boundary && (duty_new == 10'h000)) |=> !pwm_output_pin;
    endproperty
    a_zero: assert property (p_zero) else $error("pin set with zero duty");

    property p_latch;
        @(posedge pclk) disable iff (!presetn)
        boundary |=> (dbuf10 == $past(duty_new));
    endproperty
    a_latch: assert property (p_latch) else $error("duty not copied at boundary");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.pwm_en && !boundary) |=> $stable(dbuf10);
    endproperty
    a_hold: assert property (p_hold) else $error("active duty changed mid period");

    property p_readonly;
        @(posedge pclk) disable iff (!presetn)
        (buf_wr && st_reg.pwm_en && !boundary) |=> (dbuf10 == $past(dbuf10));
    endproperty
    a_readonly: assert property (p_readonly) else $error("buffer write took effect");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.pwm_en && st_reg.timer_on && !boundary && (tb_next == duty_act))
            |=> !pwm_output_pin;
    endproperty
    a_clear: assert property (p_clear) else $error("pin not cleared on match");

    property p_beyond;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.pwm_en && !boundary && (duty_act > tb_last) && !wr_en)
            |=> (pwm_output_pin == $past(pwm_output_pin));
    endproperty
    a_beyond: assert property (p_beyond) else $error("pin moved with duty past period");

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        (!tick && !tmr_wr) |=> $stable(st_reg.period_timer);
    endproperty
    a_step: assert property (p_step) else $error("timer moved between increments");

    property p_div1;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.timer_on && (st_reg.prescale == pwm_pkg::PRE_DIV1) && !tmr_wr
            && (st_reg.pre == 8'h00)) |=> ##2 (tick || $past(tmr_wr) || $past(tmr_wr, 2));
    endproperty
    a_div1: assert property (p_div1) else $error("1:1 sub-count not four clocks");

    // ------------------------------------------------------------------------
    // Timer, duty field and pin edge checks
    // ------------------------------------------------------------------------
    property p_count;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.timer_on && !tick && !tmr_wr)
            |=> (st_reg.pre == $past(st_reg.pre) + 8'h01);
    endproperty
    a_count: assert property (p_count) else $error("prescaler skipped a clock");

    property p_advance;
        @(posedge pclk) disable iff (!presetn)
        (tick && !boundary && !tmr_wr)
            |=> (st_reg.period_timer == $past(st_reg.period_timer) + 8'h01);
    endproperty
    a_advance: assert property (p_advance) else $error("timer did not step once");

    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        (!st_reg.timer_on && !tmr_wr)
            |=> ($stable(st_reg.pre) && $stable(st_reg.period_timer));
    endproperty
    a_frozen: assert property (p_frozen) else $error("stopped timer moved");

    property p_lsb;
        @(posedge pclk) disable iff (!presetn)
        ctrl_wr |=> (st_reg.duty_lsb_field == $past(lsb_wd));
    endproperty
    a_lsb: assert property (p_lsb) else $error("duty low bits not taken");

    property p_low;
        @(posedge pclk) disable iff (!presetn)
        low_wr |=> (st_reg.duty_low_register == $past(low_wd));
    endproperty
    a_low: assert property (p_low) else $error("duty high bits not taken");

    property p_apply;
        @(posedge pclk) disable iff (!presetn)
        (!boundary && !buf_wr) |=> $stable(dbuf10);
    endproperty
    a_apply: assert property (p_apply) else $error("compare value moved off boundary");

    property p_rise;
        @(posedge pclk) disable iff (!presetn)
        $rose(pwm_output_pin) |-> $past(boundary);
    endproperty
    a_rise: assert property (p_rise) else $error("pin rose off boundary");

    property p_off;
        @(posedge pclk) disable iff (!presetn)
        !st_reg.pwm_en |=> !pwm_output_pin;
    endproperty
    a_off: assert property (p_off) else $error("pin high while disabled");

    property p_fall;
        @(posedge pclk) disable iff (!presetn)
        $fell(pwm_output_pin) |-> $past(pin_clr);
    endproperty
    a_fall: assert property (p_fall) else $error("pin fell without a match");

endmodule : timer_based_pwm_output

// ===== verif/pwm_load_model.sv
// Load on the PWM pin that measures period and high time in clock cycles
`timescale 1ns/100ps

module pwm_load_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pwm_output_pin,
    output logic      [15:0] last_period,
    output logic      [15:0] last_high,
    output logic      [15:0] rises
);
    logic        prev;
    logic [15:0] run;
    logic [15:0] high;

    // ------------------------------------------------------------------------
    // Edge timing
    // ------------------------------------------------------------------------
    // Period runs rise to rise, so the first figure after a change is stale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev        <= 1'b0;
            run         <= 16'h0000;
            high        <= 16'h0000;
            last_period <= 16'h0000;
            last_high   <= 16'h0000;
            rises       <= 16'h0000;
        end else begin
            prev <= pwm_output_pin;
            if (pwm_output_pin && !prev) begin
                last_period <= run;
                rises       <= rises + 16'h0001;
                run         <= 16'h0001;
                high        <= 16'h0001;
            end else begin
                run <= run + 16'h0001;
                if (pwm_output_pin) begin
                    high <= high + 16'h0001;
                end
            end
            if (!pwm_output_pin && prev) begin
                last_high <= high;
            end
        end
    end
endmodule : pwm_load_model

// ===== verif/timer_based_pwm_output_tb.sv
// Register-level testbench of the PWM generator
`timescale 1ns/100ps
`include "pwm_defs.svh"

module timer_based_pwm_output_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_output_pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        e;
    logic [15:0] last_period, last_high, rises, r;
    int          errors, total_checks, cycles, ratio;
    logic [7:0]  offs [7] = '{`PWM_OFS_PERIOD, `PWM_OFS_DUTY_LOW, `PWM_OFS_CTRL,
                              `PWM_OFS_DUTY_BUF, `PWM_OFS_TIMER_CTRL, `PWM_OFS_TIMER,
                              `PWM_OFS_STATUS};

    timer_based_pwm_output timer_based_pwm_output_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_output_pin(pwm_output_pin));
    pwm_load_model pwm_load_model_inst (.pclk(pclk), .presetn(presetn),
        .pwm_output_pin(pwm_output_pin), .last_period(last_period), .last_high(last_high),
        .rises(rises));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------------------
    task end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Longest test is far below this; a hang ends the run here
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------------
    // APB master
    // ------------------------------------------------------------------------
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, wd, x, y);
    endtask : wr

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    function automatic logic [31:0] buf_of(input logic [9:0] duty);
        return {22'h0, duty[1:0], duty[9:2]};
    endfunction : buf_of

    task cfg(input logic [7:0] per, input logic [9:0] duty, input logic [1:0] pre,
             input logic [3:0] post, input logic en);
        wr(`PWM_OFS_PERIOD, {24'h0, per});
        wr(`PWM_OFS_DUTY_LOW, {24'h0, duty[9:2]});
        wr(`PWM_OFS_CTRL, {26'h0, duty[1:0], 3'h0, en});
        wr(`PWM_OFS_TIMER, 32'h0);
        wr(`PWM_OFS_TIMER_CTRL, {25'h0, post, 1'b1, pre});
    endtask : cfg

    task measure(input int per_clk, input int high_clk, input int wait_clk);
        repeat (wait_clk) @(posedge pclk);
        check("pwm period", per_clk, {16'h0, last_period});
        check("pwm high time", high_clk, {16'h0, last_high});
    endtask : measure

    // ------------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(offs[i]);
            check("reset value", (i == 0) ? 32'h000000ff : 32'h0, d);
            check("mapped error", 32'h0, {31'h0, e});
        end
        rd(8'h1c);
        check("unmapped error", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, d);
        // Same duty at every prescale; postscale varied but must not matter
        for (int i = 0; i < 4; i++) begin
            ratio = 1 << (2 * i);
            cfg(8'h01, 10'h005, i[1:0], 4'(i * 5), 1'b1);
            measure(8 * ratio, 5 * ratio, 24 * ratio + 20);
        end
        rd(`PWM_OFS_DUTY_BUF);
        check("duty buffer", buf_of(10'h005), d);
        wr(`PWM_OFS_DUTY_BUF, 32'h3ff);
        rd(`PWM_OFS_DUTY_BUF);
        check("duty buffer write ignored", buf_of(10'h005), d);
        cfg(8'hff, 10'h005, 2'h0, 4'h0, 1'b1);
        measure(1024, 5, 2100);
        wr(`PWM_OFS_TIMER, 32'h0);
        wr(`PWM_OFS_DUTY_LOW, 32'h80);
        wr(`PWM_OFS_CTRL, 32'h1);
        rd(`PWM_OFS_DUTY_BUF);
        check("duty held mid-period", buf_of(10'h005), d);
        measure(1024, 512, 2200);
        rd(`PWM_OFS_DUTY_BUF);
        check("duty after boundary", buf_of(10'h200), d);
        cfg(8'h01, 10'h000, 2'h0, 4'h0, 1'b1);
        repeat (40) @(posedge pclk);
        r = rises;
        repeat (40) @(posedge pclk);
        check("zero duty rises", {16'h0, r}, {16'h0, rises});
        check("zero duty pin", 32'h0, {31'h0, pwm_output_pin});
        cfg(8'h01, 10'h008, 2'h0, 4'h0, 1'b1);
        repeat (40) @(posedge pclk);
        r = rises;
        repeat (40) @(posedge pclk);
        check("over-period rises", {16'h0, r}, {16'h0, rises});
        rd(`PWM_OFS_STATUS);
        check("over-period pin", 32'h1, d);
        wr(`PWM_OFS_CTRL, 32'h0);
        repeat (4) @(posedge pclk);
        check("disabled pin", 32'h0, {31'h0, pwm_output_pin});
        // Stopped timer must hold; then the idle buffer takes a write
        wr(`PWM_OFS_TIMER_CTRL, 32'h0);
        rd(`PWM_OFS_TIMER);
        r = d[15:0];
        repeat (20) @(posedge pclk);
        rd(`PWM_OFS_TIMER);
        check("timer frozen", {16'h0, r}, d);
        wr(`PWM_OFS_DUTY_BUF, 32'h0ab);
        rd(`PWM_OFS_DUTY_BUF);
        check("duty buffer write idle", 32'h000000ab, d);
        end_of_test();
    end
endmodule : timer_based_pwm_output_tb
